// ===== src/cmd_fifo.sv
// Show-ahead FIFO with valid and ready on both sides
`timescale 1ns/1ps
module cmd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
			count  <= (AW+1)'(count + push - pop);
		end
	end
endmodule

// ===== src/tdm_access_device.sv
// Serial TDM to parallel bridge: frame timing, RAMs, three parallel modes
// Contract
// [R1] Bit cells paced by incoming timing clock
// [R2] Frame starts at timing fall after frame fall
// [R3] Vector fetch drives programmed vector on data
// [R4] Submode select low gives mode 3, high 2
// [R5] Other party selects device with chip select
// [R6] Mode 1 data strobe marks write or read
// [R7] Mode 2 data drivers follow output enable
// [R8] Mode 3 output enable low reads device
// [R9] Read/write input high reads, low writes
// [R10] Mode 3 write enable low writes device
// [R11] Other party supplies five address bits
// [R12] Mode 3 address outputs show RAM position
// [R13] Mode 1 region bit: registers or RAMs
// [R14] Mode 2 region bit picks transmit RAM
// [R15] Mode 3 channel start pulse four bits
// [R16] Eight-bit two-way data bus
// [R17] First transmit RAM serialised on output 0
// [R18] Serial input 0 stored in receive RAM
// [R19] Master mode high mode 1; low clears registers
// [R20] Mode 1 transfer ack after data valid
// [R21] Modes 2,3 channel count pin 24 or 32
// [R22] Output 1: second transmit RAM or delayed input
// [R23] Frame is 32 channels, two clocks per bit
`timescale 1ns/1ps
module tdm_access_device
	import tdm_pkg::*;
#(
	parameter int NUM_CHANNELS = tdm_pkg::CHANNELS
) (
	input  wire logic   clk,
	input  wire logic   reset,
	tdm_bus_if.device   bus,
	input  wire logic   bit_timing_clock_in,
	input  wire logic   frame_pulse_in_n,
	input  wire logic   serial_in_0,
	output logic        serial_out_0,
	output logic        serial_out_1,
	output logic        frame_start
);
	import tdm_pkg::*;

	logic [DATA_W-1:0] transmit_ram_first  [NUM_CHANNELS];
	logic [DATA_W-1:0] transmit_ram_second [NUM_CHANNELS];
	logic [DATA_W-1:0] receive_ram         [NUM_CHANNELS];

	// Two-stage synchronisers, third stage for edge detection
	logic [2:0] c4_sync;
	logic [2:0] f0_sync;
	logic [2:0] si_sync;
	logic       frame_armed;
	logic       tick;
	logic [CNT_W-1:0] cell_cnt;
	logic [DATA_W-1:0] shift_0;
	logic [DATA_W-1:0] shift_1;
	logic [DATA_W-1:0] shift_in;
	logic [DATA_W-1:0] vector;
	logic [DATA_W-1:0] control;
	logic [DATA_W-1:0] dev_data;
	logic              acked;

	wire c4_fall = c4_sync[2] && !c4_sync[1];
	wire f0_fall = f0_sync[2] && !f0_sync[1];
	wire si_bit  = si_sync[1];

	wire [CH_W-1:0] chan      = cell_cnt[CNT_W-1:4];
	wire [2:0]      bit_idx   = cell_cnt[3:1];
	wire            half      = cell_cnt[0];
	wire [3:0]      slot      = cell_cnt[3:0];

	// Mode decode from the master and submode pins
	mode_e mode;
	assign mode = !bus.master_mode_select ? (bus.submode_select ? MODE_FAST_RAM  // R4
		: MODE_CONTROLLER) : MODE_PERIPH;  // R19
	wire is_m1 = mode == MODE_PERIPH;
	wire is_m2 = mode == MODE_FAST_RAM;
	wire is_m3 = mode == MODE_CONTROLLER;

	// Short frame in modes 2,3 from pin, in mode 1 from control
	wire short_frame = is_m1 ? control[CTRL_SHORT] : !bus.channel_count_32;  // R21
	wire chan_valid  = !short_frame || (chan < CH_W'(CHANNELS_SHORT));

	wire selected = !bus.chip_select_n;  // R5
	wire m1_req   = is_m1 && selected && !bus.data_strobe_n;  // R6
	wire m1_start = m1_req && !acked;
	wire is_read  = bus.read_write;  // R9
	wire [4:0] addr = bus.low_address_bits;  // R11
	wire [DATA_W-1:0] bus_in = bus.parallel_data_bus;  // R16

	wire [DATA_W-1:0] reg_read =
		(addr == REG_VECTOR)  ? vector :
		(addr == REG_CONTROL) ? control :
		(addr == REG_CHANNEL) ? DATA_W'(chan) : '0;
	wire [DATA_W-1:0] m1_read =
		!bus.vector_fetch_ack_n ? vector :  // R3
		bus.region_select_bit ? reg_read : receive_ram[addr];  // R13

	wire m1_reg_wr = m1_start && !is_read && bus.vector_fetch_ack_n && bus.region_select_bit;
	wire m1_ram_wr = m1_start && !is_read && bus.vector_fetch_ack_n && !bus.region_select_bit;
	wire m2_wr     = is_m2 && selected && !is_read;
	wire tx_second = is_m2 ? bus.region_select_bit : control[CTRL_TX_SEL];  // R14

	wire m3_rd_win = is_m3 && chan_valid && bit_idx >= RD_BIT_LO && bit_idx <= RD_BIT_HI;
	wire m3_wr_win = is_m3 && chan_valid && bit_idx >= WR_BIT_LO && bit_idx <= WR_BIT_HI;
	wire m3_capture = tick && is_m3 && chan_valid && bit_idx == RD_BIT_HI && half;

	// Mode 3 bus control outputs
	assign bus.output_enable_out_n   = !m3_rd_win;  // R8
	assign bus.write_enable_n        = !m3_wr_win;  // R10
	assign bus.channel_start_pulse_n = !(is_m3 && chan_valid && bit_idx < CHANNEL_START_PULSE_N_BITS);  // R15
	assign bus.address_out           = chan;  // R12

	// Data drivers per mode
	assign bus.dev_data_o  = dev_data;
	assign bus.dev_data_oe = (m1_req && acked && (is_read || !bus.vector_fetch_ack_n))
		|| (is_m2 && selected && is_read && !bus.data_strobe_n)  // R7
		|| m3_wr_win;  // R16
	assign bus.transfer_ack_o  = 1'b0;
	assign bus.transfer_ack_oe = m1_req && acked;  // R20

	always_ff @(posedge clk) begin
		if (reset) begin
			c4_sync <= '0;
			f0_sync <= '1;
			si_sync <= '1;
		end else begin
			c4_sync <= {c4_sync[1:0], bit_timing_clock_in};
			f0_sync <= {f0_sync[1:0], frame_pulse_in_n};
			si_sync <= {si_sync[1:0], serial_in_0};
		end
	end

	// Frame alignment and bit cell count
	always_ff @(posedge clk) begin
		if (reset) begin
			frame_armed <= 1'b0;
			cell_cnt    <= '0;
			tick        <= 1'b0;
			frame_start <= 1'b0;
		end else begin
			tick        <= c4_fall;  // R1
			frame_start <= c4_fall && frame_armed && !f0_fall;
			if (f0_fall) begin
				frame_armed <= 1'b1;
			end else if (c4_fall && frame_armed) begin
				frame_armed <= 1'b0;
			end
			if (c4_fall) begin
				cell_cnt <= (frame_armed && !f0_fall) ? '0  // R2
					: CNT_W'(cell_cnt + 1'b1);  // R23
			end
		end
	end

	// Serial shifters: load at channel start, shift once per bit (every second cell)
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_0  <= IDLE_BYTE;
			shift_1  <= IDLE_BYTE;
			shift_in <= '0;
		end else if (tick) begin
			if (slot == SLOT_FIRST) begin
				shift_0 <= chan_valid ? transmit_ram_first[chan] : IDLE_BYTE;  // R17
				shift_1 <= !chan_valid ? IDLE_BYTE
					: (is_m3 ? receive_ram[chan] : transmit_ram_second[chan]);  // R22
			end else if (!half) begin
				shift_0 <= {shift_0[DATA_W-2:0], 1'b1};
				shift_1 <= {shift_1[DATA_W-2:0], 1'b1};
			end
			if (half) begin
				shift_in <= {shift_in[DATA_W-2:0], si_bit};  // R18
			end
		end
	end
	assign serial_out_0 = shift_0[DATA_W-1];
	assign serial_out_1 = shift_1[DATA_W-1];

	// Receive RAM written at the last half of each valid channel
	always_ff @(posedge clk) begin
		if (tick && half && slot == SLOT_LAST && chan_valid) begin
			receive_ram[chan] <= {shift_in[DATA_W-2:0], si_bit};  // R18
		end
	end

	// Transmit RAM writes from parallel side
	always_ff @(posedge clk) begin
		if (m3_capture) begin
			transmit_ram_first[chan] <= bus_in;
		end else if ((m1_ram_wr || m2_wr) && !tx_second) begin
			transmit_ram_first[addr] <= bus_in;  // R14
		end
		if ((m1_ram_wr || m2_wr) && tx_second) begin
			transmit_ram_second[addr] <= bus_in;  // R14
		end
	end

	// Peripheral registers, cleared while master mode is low
	always_ff @(posedge clk) begin
		if (reset || !bus.master_mode_select) begin
			vector  <= VECTOR_RST;  // R19
			control <= CONTROL_RST;
		end else if (m1_reg_wr) begin
			if (addr == REG_VECTOR) begin
				vector <= bus_in;
			end
			if (addr == REG_CONTROL) begin
				control <= bus_in;
			end
		end
	end

	// Peripheral handshake and read data
	always_ff @(posedge clk) begin
		if (reset) begin
			acked    <= 1'b0;
			dev_data <= '0;
		end else begin
			acked <= m1_req;  // R20
			// Follow the current channel all through mode 3, so a write window
			// entered part way after a mode change still drives this channel
			if (is_m3) begin
				dev_data <= receive_ram[chan];
			end else if (m1_start) begin
				dev_data <= m1_read;  // R6
			end else if (is_m2) begin
				dev_data <= receive_ram[addr];  // R7
			end
		end
	end
endmodule

// ===== src/tdm_access_host.sv
// Outside party: drives mode pins, runs queued accesses, serves mode 3
`timescale 1ns/1ps
module tdm_access_host
	import tdm_pkg::*;
#(
	parameter int FIFO_DEPTH = tdm_pkg::CMD_FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              reset,
	tdm_bus_if.host                bus,
	input  wire logic              mode_master,
	input  wire logic              mode_sub,
	input  wire logic              chan32,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_write,
	input  wire logic              cmd_vector,
	input  wire logic              cmd_region,
	input  wire logic [4:0]        cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_data,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_data,
	input  wire logic [DATA_W-1:0] ext_read_data,
	output logic                   ext_write_valid,
	output logic      [4:0]        ext_write_addr,
	output logic      [DATA_W-1:0] ext_write_data
);
	import tdm_pkg::*;

	localparam int CMD_W = 3 + 5 + DATA_W;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_FINISH = 2'b10
	} host_state_e;

	host_state_e state;
	logic [CMD_W-1:0] cur;
	logic [1:0]       wait_cnt;
	logic             we_seen;
	logic             q_valid;
	logic             q_ready;
	logic [CMD_W-1:0] q_data;

	cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.reset    (reset),
		.in_valid (cmd_valid),
		.in_ready (cmd_ready),
		.in_data  ({cmd_write, cmd_vector, cmd_region, cmd_addr, cmd_data}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data (q_data)
	);

	wire in_m1   = mode_master;
	wire in_m3   = !mode_master && !mode_sub;
	wire cur_wr  = cur[CMD_W-1];
	wire cur_vec = cur[CMD_W-2];
	wire active  = state == ST_ACCESS;
	wire done    = in_m1 ? !bus.transfer_ack_n : (wait_cnt == FAST_READ_CYCLES);

	assign q_ready = state == ST_IDLE && !in_m3;

	assign bus.master_mode_select = mode_master;
	assign bus.submode_select     = in_m1 ? !(active && cur_vec) : mode_sub;
	assign bus.vector_fetch_ack_n = !(active && cur_vec);
	assign bus.channel_count_32   = chan32;
	assign bus.chip_select_n      = !active;  // R5
	assign bus.data_strobe_n      = !(active && (in_m1 || !cur_wr));
	assign bus.read_write         = !(active && cur_wr);  // R9
	assign bus.low_address_bits   = cur[DATA_W+4:DATA_W];  // R11
	assign bus.region_select_bit  = cur[DATA_W+5];
	assign bus.host_data_o        = in_m3 ? ext_read_data : cur[DATA_W-1:0];
	assign bus.host_data_oe       = (active && cur_wr) || (in_m3 && !bus.output_enable_out_n);

	always_ff @(posedge clk) begin
		if (reset) begin
			state     <= ST_IDLE;
			cur       <= '0;
			wait_cnt  <= '0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					wait_cnt <= '0;
					if (q_valid && q_ready) begin
						cur   <= q_data;
						state <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					wait_cnt <= 2'(wait_cnt + 1'b1);
					if (done) begin
						rsp_valid <= !cur_wr;
						rsp_data  <= bus.parallel_data_bus;
						state     <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Mode 3: one write per write-enable window, caught at its end
	always_ff @(posedge clk) begin
		if (reset) begin
			we_seen         <= 1'b0;
			ext_write_valid <= 1'b0;
			ext_write_addr  <= '0;
			ext_write_data  <= '0;
		end else begin
			we_seen         <= in_m3 && !bus.write_enable_n;
			ext_write_valid <= we_seen && bus.write_enable_n;
			if (in_m3 && !bus.write_enable_n) begin
				ext_write_addr <= bus.address_out;
				ext_write_data <= bus.parallel_data_bus;
			end
		end
	end
endmodule

// ===== src/tdm_bus_if.sv
// Parallel pins between the bridge and its outside party
`timescale 1ns/1ps
interface tdm_bus_if;
	logic       master_mode_select;
	logic       submode_select;
	logic       vector_fetch_ack_n;
	logic       channel_count_32;
	logic       chip_select_n;
	logic       data_strobe_n;
	logic       read_write;
	logic [4:0] low_address_bits;
	logic       region_select_bit;
	logic [4:0] address_out;
	logic       output_enable_out_n;
	logic       write_enable_n;
	logic       channel_start_pulse_n;
	logic [7:0] host_data_o;
	logic       host_data_oe;
	logic [7:0] dev_data_o;
	logic       dev_data_oe;
	logic       transfer_ack_o;
	logic       transfer_ack_oe;
	wire  [7:0] parallel_data_bus;
	wire        transfer_ack_n;

	// Wire levels from the enables; undriven bus and ack float high
	assign parallel_data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hff);
	assign transfer_ack_n    = transfer_ack_oe ? transfer_ack_o : 1'b1;

	modport device (
		input  master_mode_select, submode_select, vector_fetch_ack_n, channel_count_32,
		input  chip_select_n, data_strobe_n, read_write, low_address_bits,
		input  region_select_bit, parallel_data_bus,
		output address_out, output_enable_out_n, write_enable_n, channel_start_pulse_n,
		output dev_data_o, dev_data_oe, transfer_ack_o, transfer_ack_oe
	);
	modport host (
		output master_mode_select, submode_select, vector_fetch_ack_n, channel_count_32,
		output chip_select_n, data_strobe_n, read_write, low_address_bits,
		output region_select_bit, host_data_o, host_data_oe,
		input  address_out, output_enable_out_n, write_enable_n, channel_start_pulse_n,
		input  parallel_data_bus, transfer_ack_n
	);
endinterface

// ===== src/tdm_pkg.sv
// Shared constants and types for the serial TDM parallel access bridge
package tdm_pkg;
	localparam int TIMING_CLOCK_KHZ = 4096;
	localparam int CLK_KHZ          = 200000;
	localparam int CHANNELS         = 32;
	localparam int CHANNELS_SHORT   = 24;
	localparam int BITS_PER_CHAN    = 8;
	localparam int CLKS_PER_BIT     = 2;
	localparam int CNT_W            = 9;
	localparam int CH_W             = 5;
	localparam int DATA_W           = 8;
	localparam int CMD_FIFO_DEPTH   = 16;

	// Position of one timing clock edge in the frame: channel, bit, half
	localparam logic [3:0] SLOT_FIRST  = 4'h0;
	localparam logic [3:0] SLOT_LAST   = 4'hf;
	localparam logic [2:0] CHANNEL_START_PULSE_N_BITS   = 3'h4;
	localparam logic [2:0] RD_BIT_LO   = 3'h1;
	localparam logic [2:0] RD_BIT_HI   = 3'h2;
	localparam logic [2:0] WR_LOAD_BIT = 3'h4;
	localparam logic [2:0] WR_BIT_LO   = 3'h5;
	localparam logic [2:0] WR_BIT_HI   = 3'h6;

	// Peripheral mode registers, word index on the low address bits
	localparam logic [4:0] REG_VECTOR  = 5'h00;
	localparam logic [4:0] REG_CONTROL = 5'h01;
	localparam logic [4:0] REG_CHANNEL = 5'h02;
	localparam int         CTRL_TX_SEL = 0;
	localparam int         CTRL_SHORT  = 5;
	localparam logic [7:0] VECTOR_RST  = 8'h0f;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] IDLE_BYTE   = 8'hff;

	// Fast RAM read taken two cycles after the address
	localparam logic [1:0] FAST_READ_CYCLES = 2'h2;

	typedef enum logic [1:0] {
		MODE_PERIPH     = 2'b01,
		MODE_FAST_RAM   = 2'b10,
		MODE_CONTROLLER = 2'b11
	} mode_e;
endpackage

// ===== verif/tb_top.sv
// Bench joining both bridge ends; drives the serial side and host commands
`timescale 1ns/1ps
`define CHECK(g, e) check_val(8'(g), 8'(e))
module tb_top;
	import tdm_pkg::*;
	logic        clk = 0, reset = 1, tclk = 0, frame_n = 1, sin = 1, w0 = 0, w1 = 0;
	logic        ok, ext_seen = 0, mode_master = 1, mode_sub = 1, chan32 = 1;
	logic        cmd_valid = 0, cmd_write = 0, cmd_vector = 0, cmd_region = 0;
	logic [4:0]  cmd_addr = 5'h00;
	logic [7:0]  cmd_data = 8'h00, ext_read_data = 8'h00, vec, sbyte;
	logic [8:0]  tpos = 9'h1c0;
	logic [31:0] seed = 32'hf39b;
	logic [7:0]  tx0 [32], tx1 [32], expq [$];
	logic        cmd_ready, rsp_valid, ext_write_valid, serial_out_0, serial_out_1, frame_start;
	logic [7:0]  rsp_data, ext_write_data;
	logic [4:0]  ext_write_addr;
	int          failures = 0, comparisons = 0, i, n;

	tdm_bus_if tdm_bus_if_inst ();
	tdm_access_device tdm_access_device_inst (.clk(clk), .reset(reset), .bus(tdm_bus_if_inst),
		.bit_timing_clock_in(tclk), .frame_pulse_in_n(frame_n), .serial_in_0(sin),
		.serial_out_0(serial_out_0), .serial_out_1(serial_out_1), .frame_start(frame_start));
	tdm_access_host tdm_access_host_inst (.clk(clk), .reset(reset), .bus(tdm_bus_if_inst),
		.mode_master(mode_master), .mode_sub(mode_sub), .chan32(chan32),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_vector(cmd_vector), .cmd_region(cmd_region), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.ext_read_data(ext_read_data), .ext_write_valid(ext_write_valid),
		.ext_write_addr(ext_write_addr), .ext_write_data(ext_write_data));
	tdm_checker tdm_checker_inst (.clk(clk), .reset(reset),
		.master_mode_select(tdm_bus_if_inst.master_mode_select),
		.submode_select(tdm_bus_if_inst.submode_select),
		.channel_count_32(tdm_bus_if_inst.channel_count_32),
		.chip_select_n(tdm_bus_if_inst.chip_select_n),
		.data_strobe_n(tdm_bus_if_inst.data_strobe_n),
		.read_write(tdm_bus_if_inst.read_write), .address_out(tdm_bus_if_inst.address_out),
		.output_enable_out_n(tdm_bus_if_inst.output_enable_out_n),
		.write_enable_n(tdm_bus_if_inst.write_enable_n),
		.channel_start_pulse_n(tdm_bus_if_inst.channel_start_pulse_n),
		.dev_data_oe(tdm_bus_if_inst.dev_data_oe),
		.transfer_ack_n(tdm_bus_if_inst.transfer_ack_n));

	function automatic logic [7:0] pat(input logic [4:0] ch);
		return {3'h5, ch} ^ 8'h3c;
	endfunction
	function automatic logic [7:0] rdpat(input logic [4:0] ch);
		return ~{ch, 3'h2};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic give_up;
		failures++;
		end_of_test;
	endtask
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// Offer one command; valid held until ready is seen at an edge or lim edges pass
	task automatic push(input logic wr, vc, rg, input logic [4:0] a, input logic [7:0] d,
			input int lim, output logic acc);
		int k;
		@(posedge clk);
		#1;
		{cmd_write, cmd_vector, cmd_region, cmd_addr, cmd_data} = {wr, vc, rg, a, d};
		cmd_valid = 1;
		acc = 0;
		for (k = 0; k < lim && !acc; k++) begin
			@(posedge clk);
			acc = (cmd_ready === 1'b1);
		end
		#1 cmd_valid = 0;
	endtask
	// Reads carry their expected byte in d
	task automatic op(input logic wr, vc, rg, input logic [4:0] a, input logic [7:0] d);
		logic acc;
		if (!wr) expq.push_back(d);
		push(wr, vc, rg, a, d, 400, acc);
		if (!acc) give_up;
	endtask
	task automatic drain;
		int k;
		for (k = 0; k < 3000 && expq.size() > 0; k++) @(posedge clk);
		if (expq.size() > 0) give_up;
		repeat (4) @(posedge clk);
	endtask
	task automatic wait_fs;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (frame_start !== 1'b1 && k < 30000);
		if (frame_start !== 1'b1) give_up;
	endtask
	task automatic watch(input logic a, b);
		wait_fs;
		{w0, w1} = {a, b};
		wait_fs;
		{w0, w1} = 2'b00;
	endtask
	task automatic set_mode(input logic m, s, c);
		@(posedge clk);
		#1 {mode_master, mode_sub, chan32} = {m, s, c};
		repeat (8) @(posedge clk);
	endtask

	always #2.5 clk = ~clk;
	always #122.070 tclk = ~tclk;
	always @(posedge tclk) frame_n <= (tpos != 9'h1ff);
	// Serial input: channel pattern, most significant bit first
	always @(negedge tclk) begin
		tpos = tpos + 9'h001;
		sbyte = pat(tpos[8:4]);
		sin = sbyte[~tpos[3:1]];
	end
	always @(posedge tclk) if (tpos[0]) begin
		if (w0) `CHECK(serial_out_0, tx0[tpos[8:4]][~tpos[3:1]]);
		if (w1) `CHECK(serial_out_1, tx1[tpos[8:4]][~tpos[3:1]]);
	end
	always @(posedge clk) ext_read_data <= #1 rdpat(tdm_bus_if_inst.address_out);
	always @(posedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (expq.size() > 0) `CHECK(rsp_data, expq.pop_front());
			else give_up;
		end
		if (ext_write_valid === 1'b1) begin
			ext_seen <= 1;
			`CHECK(ext_write_data, pat(ext_write_addr));
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		#1 reset = 0;
		op(0, 0, 1, REG_VECTOR, VECTOR_RST);
		op(0, 0, 1, REG_CONTROL, CONTROL_RST);
		op(0, 0, 1, 5'h1f, 8'h00);
		seed = lfsr(seed);
		vec = seed[7:0];
		op(1, 0, 1, REG_VECTOR, vec);
		op(0, 1, 0, seed[12:8], vec);
		for (i = 0; i < 64; i++) begin
			if (i == 32) op(1, 0, 1, REG_CONTROL, 8'h01);
			seed = lfsr(seed);
			if (i < 32) tx0[i] = seed[7:0];
			else tx1[i - 32] = seed[7:0];
			op(1, 0, 0, 5'(i), seed[7:0]);
		end
		op(1, 0, 1, REG_CONTROL, CONTROL_RST);
		drain;
		watch(1, 1);
		for (i = 0; i < 32; i++) op(0, 0, 0, 5'(i), pat(5'(i)));
		drain;
		set_mode(0, 1, 1);
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			op(1, 0, seed[5], seed[12:8], seed[23:16]);
			op(0, 0, seed[6], seed[4:0], pat(seed[4:0]));
		end
		drain;
		set_mode(0, 0, 0);
		n = 0;
		for (i = 0; i < 20; i++) begin
			push(0, i == 0, 0, 5'(i), 8'h00, 3, ok);
			if (ok) n++;
			if (ok) expq.push_back(i == 0 ? VECTOR_RST : pat(5'(i)));
		end
		`CHECK(n, CMD_FIFO_DEPTH);
		for (i = 0; i < 32; i++) tx1[i] = i < CHANNELS_SHORT ? pat(5'(i)) : IDLE_BYTE;
		watch(0, 1);
		`CHECK(ext_seen, 1);
		set_mode(1, 1, 1);
		drain;
		end_of_test;
	end
endmodule

// ===== verif/tdm_checker.sv
// Concurrent checks on the parallel pins between the two bridge ends
`timescale 1ns/1ps
module tdm_checker (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       master_mode_select,
	input wire logic       submode_select,
	input wire logic       channel_count_32,
	input wire logic       chip_select_n,
	input wire logic       data_strobe_n,
	input wire logic       read_write,
	input wire logic [4:0] address_out,
	input wire logic       output_enable_out_n,
	input wire logic       write_enable_n,
	input wire logic       channel_start_pulse_n,
	input wire logic       dev_data_oe,
	input wire logic       transfer_ack_n
);
	logic [2:0] mode_d1;
	logic [2:0] mode_d2;
	logic       channel_start_pulse_n_d;
	logic       full_pulse;
	logic [9:0] low_cnt;
	wire  [2:0] mode_now = {master_mode_select, submode_select, channel_count_32};
	wire        steady   = (mode_now == mode_d1) && (mode_d1 == mode_d2);
	wire        steady3  = steady && !master_mode_select && !submode_select;

	// Mode pins held two cycles before checks other than ack_needs_strobe_a and ack_read_data_a trust them
	always_ff @(posedge clk) begin
		mode_d1 <= mode_now;
		mode_d2 <= mode_d1;
		channel_start_pulse_n_d  <= channel_start_pulse_n;
	end

	// Length of a start pulse seen whole in mode 3
	always_ff @(posedge clk) begin
		if (reset || !steady3) begin
			full_pulse <= 1'b0;
			low_cnt    <= 10'h000;
		end else if (channel_start_pulse_n_d && !channel_start_pulse_n) begin
			full_pulse <= 1'b1;
			low_cnt    <= 10'h001;
		end else if (!channel_start_pulse_n) begin
			low_cnt <= low_cnt + 10'h001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	ack_follows_strobe_a:
	assert property (steady && master_mode_select && !chip_select_n && !data_strobe_n
		&& transfer_ack_n |=> !transfer_ack_n || chip_select_n || data_strobe_n)
		else $error("no acknowledge after strobe");
	ack_needs_strobe_a:
	assert property (!transfer_ack_n |-> master_mode_select && !chip_select_n && !data_strobe_n)
		else $error("acknowledge without access");
	ack_read_data_a:
	assert property (!transfer_ack_n && read_write |-> dev_data_oe)
		else $error("read acknowledged without data");
	fast_read_drive_a:
	assert property (steady && !master_mode_select && submode_select && !chip_select_n
		&& !data_strobe_n && read_write |-> ##[0:1] dev_data_oe)
		else $error("fast read not driven");
	fast_oe_follow_a:
	assert property (steady && !master_mode_select && submode_select && dev_data_oe
		|-> !chip_select_n && !data_strobe_n && read_write)
		else $error("fast mode drives without enable");
	ctrl_read_free_a:
	assert property (steady3 && !output_enable_out_n
		|-> !dev_data_oe && write_enable_n && !channel_start_pulse_n)
		else $error("read window wrong");
	ctrl_write_drive_a:
	assert property (steady3 && !write_enable_n |-> dev_data_oe && channel_start_pulse_n)
		else $error("write window wrong");
	start_pulse_width_a:
	assert property (steady3 && full_pulse && $rose(channel_start_pulse_n)
		|-> low_cnt >= 10'd385 && low_cnt <= 10'd396)
		else $error("start pulse width wrong");
	addr_hold_a:
	assert property (steady3 && !channel_start_pulse_n && !channel_start_pulse_n_d |-> $stable(address_out))
		else $error("address moved inside channel");
	short_frame_a:
	assert property (steady3 && !channel_count_32 && !channel_start_pulse_n
		|-> address_out < 5'h18)
		else $error("channel beyond short frame");
endmodule
